// File: irq_flags_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef IRQ_FLAGS_DEFS_SVH
`define IRQ_FLAGS_DEFS_SVH
`define OFS_PERIPH_FLAGS 8'h00
`define OFS_WAKE_FLAGS 8'h04
`define OFS_WAKE_EDGE 8'h08
`define OFS_WAKE_CFG 8'h0c
`define OFS_PERIPH_EN 8'h10
`define OFS_CTRL 8'h14
`define OFS_EVT_STATUS 8'h18
`define OFS_EVT_MASK 8'h1c
`define OFS_RESET_STATE 8'h20
`define BIT_SLEEP 7
`define BIT_CONV 6
`define BIT_TMR_HI 3
`define BIT_TMR_LO 2
`define BIT_EVC 0
`define PERIPH_USED_MASK 8'hcd
`define CTRL_DT_ENABLE 0
`define CTRL_TMR_16 1
`define CTRL_EVC_16 2
`define RST_VECTOR_ADDR 16'h0000
`define RST_VECTOR_ADDR_HI 16'h0001
`define FLAGS_RESET 8'h00
`define EDGE_RESET 8'h00
`define RES_MIN_NS 80
`define CLK_PERIOD_NS 8
`define RES_MIN_CYCLES ((`RES_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: irq_flags_pkg.sv
// Types shared by the interrupt flag block
package irq_flags_pkg;
  typedef struct packed {
    logic sleep_direct;
    logic conv_end_busy_low;
    logic [7:0] timer_count_high;
    logic [7:0] timer_count_low;
    logic [7:0] timer_compare_high;
    logic [7:0] timer_compare_low;
    logic event_count_upper_ovf;
    logic event_count_lower_ovf;
  } periph_events_t;
  typedef struct packed {
    logic mask_set;
    logic fetch_req;
    logic [15:0] fetch_addr;
  } reset_ctl_t;
  typedef enum logic [1:0] {RS_HALT, RS_MASK, RS_FETCH, RS_RUN} reset_state_t;
endpackage

// File: irq_flags_wakeup_reset.sv
// Interrupt request flags, wakeup flags and reset entry with AHB-Lite registers
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "irq_flags_defs.svh"
module irq_flags_wakeup_reset (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire irq_flags_pkg::periph_events_t events,
  input wire logic [7:0] wakeup_pin,
  input wire logic vector_done,
  output logic [7:0] periph_request,
  output logic wakeup_request,
  output logic condition_code_mask,
  output logic vector_fetch_req,
  output logic [15:0] vector_fetch_addr,
  output logic irq
);
  import irq_flags_pkg::*;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [7:0] periph_flags_r;
  logic [7:0] periph_flags_nxt;
  logic [7:0] wake_flags_r;
  logic [7:0] wake_flags_nxt;
  logic [7:0] wake_edge_r;
  logic [7:0] wake_cfg_r;
  logic [7:0] periph_en_r;
  logic [2:0] ctrl_r;
  logic [1:0] evt_status_r;
  logic [1:0] evt_status_nxt;
  logic [1:0] evt_mask_r;
  logic busy_d_r;
  logic [31:0] hrdata_r;
  logic [7:0] periph_request_r;
  logic wakeup_request_r;
  logic ccr_mask_r;
  logic fetch_req_r;
  logic [15:0] fetch_addr_r;
  logic irq_r;
  logic [7:0] edge_seen;
  reset_ctl_t rst_ctl;
  reset_state_t rst_state;

  wake_edge_detect u_wake (
    .hclk(hclk),
    .hresetn(hresetn),
    .wakeup_pin(wakeup_pin),
    .wakeup_edge_select(wake_edge_r),
    .pin_is_wakeup(wake_cfg_r),
    .edge_seen(edge_seen)
  );
  reset_sequencer u_rst (
    .hclk(hclk),
    .hresetn(hresetn),
    .vector_done(vector_done),
    .ctl(rst_ctl),
    .state(rst_state)
  );

  // Bus decode; the slave never stalls, so every access is zero-wait and OKAY
  wire addr_phase = hsel && hready && htrans[1];
  wire wr_en = wr_pend_r;
  wire rd_en = addr_phase && !hwrite;
  wire [7:0] rd_addr = haddr[7:0];
  wire [7:0] wd = hwdata[7:0];
  wire wr_pf = wr_en && (wr_addr_r == `OFS_PERIPH_FLAGS);
  wire wr_wf = wr_en && (wr_addr_r == `OFS_WAKE_FLAGS);
  wire wr_we = wr_en && (wr_addr_r == `OFS_WAKE_EDGE);
  wire wr_wc = wr_en && (wr_addr_r == `OFS_WAKE_CFG);
  wire wr_pe = wr_en && (wr_addr_r == `OFS_PERIPH_EN);
  wire wr_ct = wr_en && (wr_addr_r == `OFS_CTRL);
  wire wr_es = wr_en && (wr_addr_r == `OFS_EVT_STATUS);
  wire wr_em = wr_en && (wr_addr_r == `OFS_EVT_MASK);

  // Peripheral event sources
  wire tmr16 = ctrl_r[`CTRL_TMR_16];
  wire evc16 = ctrl_r[`CTRL_EVC_16];
  wire busy_fall = busy_d_r && !events.conv_end_busy_low;
  wire hi_match = tmr16 ?
    ({events.timer_count_high, events.timer_count_low} ==
     {events.timer_compare_high, events.timer_compare_low}) :
    (events.timer_count_high == events.timer_compare_high);
  wire lo_match = !tmr16 && (events.timer_count_low == events.timer_compare_low);
  wire evc_ovf = events.event_count_upper_ovf || (!evc16 && events.event_count_lower_ovf);
  wire [7:0] periph_set;
  assign periph_set[`BIT_SLEEP] = events.sleep_direct && ctrl_r[`CTRL_DT_ENABLE];
  assign periph_set[`BIT_CONV] = busy_fall;
  assign periph_set[5:4] = 2'b00;
  assign periph_set[`BIT_TMR_HI] = hi_match;
  assign periph_set[`BIT_TMR_LO] = lo_match;
  assign periph_set[1] = 1'b0;
  assign periph_set[`BIT_EVC] = evc_ovf;

  // Writing zero clears, one keeps; a same-cycle set beats the clear
  wire [7:0] pf_keep = wr_pf ? (periph_flags_r & wd) : periph_flags_r;
  assign periph_flags_nxt = (pf_keep | periph_set) & `PERIPH_USED_MASK;
  wire [7:0] wf_keep = wr_wf ? (wake_flags_r & wd) : wake_flags_r;
  assign wake_flags_nxt = wf_keep | edge_seen;

  // Summary events for the software interrupt output
  wire [1:0] evt_set = {|edge_seen, |periph_set};
  wire [1:0] es_keep = wr_es ? (evt_status_r & ~hwdata[1:0]) : evt_status_r;
  assign evt_status_nxt = es_keep | evt_set;

  wire [7:0] rd_mux =
    (rd_addr == `OFS_PERIPH_FLAGS) ? periph_flags_r :
    (rd_addr == `OFS_WAKE_FLAGS) ? wake_flags_r :
    (rd_addr == `OFS_WAKE_EDGE) ? wake_edge_r :
    (rd_addr == `OFS_WAKE_CFG) ? wake_cfg_r :
    (rd_addr == `OFS_PERIPH_EN) ? periph_en_r :
    (rd_addr == `OFS_CTRL) ? {5'h00, ctrl_r} :
    (rd_addr == `OFS_EVT_STATUS) ? {6'h00, evt_status_r} :
    (rd_addr == `OFS_EVT_MASK) ? {6'h00, evt_mask_r} :
    (rd_addr == `OFS_RESET_STATE) ? {6'h00, rst_state} : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_phase && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  // All flags and settings initialise while the reset pin is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_flags_r <= `FLAGS_RESET;
      wake_flags_r <= `FLAGS_RESET;
      wake_edge_r <= `EDGE_RESET;
      wake_cfg_r <= 8'h00;
      periph_en_r <= 8'h00;
      ctrl_r <= 3'h0;
      evt_status_r <= 2'h0;
      evt_mask_r <= 2'h0;
      busy_d_r <= 1'b0;
    end else begin
      periph_flags_r <= periph_flags_nxt;
      wake_flags_r <= wake_flags_nxt;
      evt_status_r <= evt_status_nxt;
      busy_d_r <= events.conv_end_busy_low;
      if (wr_we) wake_edge_r <= wd;
      if (wr_wc) wake_cfg_r <= wd;
      if (wr_pe) periph_en_r <= wd & `PERIPH_USED_MASK;
      if (wr_ct) ctrl_r <= wd[2:0];
      if (wr_em) evt_mask_r <= hwdata[1:0];
    end
  end

  // Registered outputs; peripheral requests only reach the controller when enabled in periph_en_r
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
      periph_request_r <= 8'h00;
      wakeup_request_r <= 1'b0;
      ccr_mask_r <= 1'b0;
      fetch_req_r <= 1'b0;
      fetch_addr_r <= 16'h0000;
      irq_r <= 1'b0;
    end else begin
      hrdata_r <= rd_en ? {24'h000000, rd_mux} : 32'h00000000;
      periph_request_r <= periph_flags_nxt & periph_en_r;
      wakeup_request_r <= |wake_flags_nxt;
      if (rst_ctl.mask_set) ccr_mask_r <= 1'b1;
      fetch_req_r <= rst_ctl.fetch_req && !vector_done;
      fetch_addr_r <= rst_ctl.fetch_addr;
      irq_r <= |(evt_status_nxt & evt_mask_r);
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign periph_request = periph_request_r;
  assign wakeup_request = wakeup_request_r;
  assign condition_code_mask = ccr_mask_r;
  assign vector_fetch_req = fetch_req_r;
  assign vector_fetch_addr = fetch_addr_r;
  assign irq = irq_r;

  a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(periph_flags_r[0]) |-> $past(wr_pf) && !$past(wd[0])) else $error("flag cleared without zero write");
  a_sleep_set: assert property (@(posedge hclk) disable iff (!hresetn)
    events.sleep_direct && ctrl_r[`CTRL_DT_ENABLE] |=> periph_flags_r[`BIT_SLEEP]) else $error("sleep flag missed");
  a_conv_set: assert property (@(posedge hclk) disable iff (!hresetn)
    busy_fall |=> periph_flags_r[`BIT_CONV]) else $error("conversion flag missed");
  a_low_match: assert property (@(posedge hclk) disable iff (!hresetn)
    tmr16 && !periph_flags_r[`BIT_TMR_LO] |=> !periph_flags_r[`BIT_TMR_LO]) else $error("low flag in 16-bit");
  a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    periph_flags_r[5:4] == 2'b00 && !periph_flags_r[1]) else $error("unused bit set");
  a_wake_set: assert property (@(posedge hclk) disable iff (!hresetn)
    edge_seen[0] |=> wake_flags_r[0] ##1 wake_flags_r[0] || $past(wr_wf)) else $error("wake flag lost");
  a_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pf && periph_set[`BIT_EVC] |=> periph_flags_r[`BIT_EVC]) else $error("set lost to clear");
  a_enable_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    periph_request_r != 8'h00 |-> ($past(periph_flags_nxt) & $past(periph_en_r)) == periph_request_r)
    else $error("request without enable");
  a_mask_first: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(fetch_req_r) |-> ccr_mask_r) else $error("fetch before mask");
endmodule

// File: irq_flags_wakeup_reset_tb.sv
// Self-checking bench for the request flags, wakeup flags and reset entry
`timescale 1ns/1ns
`include "irq_flags_defs.svh"
module irq_flags_wakeup_reset_tb;
  import irq_flags_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, vector_done;
  logic wakeup_request, condition_code_mask, vector_fetch_req, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [7:0] wakeup_pin, periph_request;
  logic [15:0] vector_fetch_addr;
  logic [3:0] fetch_wait;
  periph_events_t events;
  int n_errors, n_checks, cycles, i;
  irq_flags_wakeup_reset u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .events(events), .wakeup_pin(wakeup_pin), .vector_done(vector_done),
    .periph_request(periph_request), .wakeup_request(wakeup_request),
    .condition_code_mask(condition_code_mask), .vector_fetch_req(vector_fetch_req),
    .vector_fetch_addr(vector_fetch_addr), .irq(irq));
  periph_source_model u_src (.hclk(hclk), .fetch_req(vector_fetch_req), .fetch_addr(vector_fetch_addr),
    .fetch_wait(fetch_wait), .ev(events), .vector_done(vector_done));
  initial begin
    hclk = 1'h0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t timeout", $time);
      give_verdict;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Address phase held until hready, then data phase held until hready again
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'h0, a, 32'h0);
    chk(q, e, m);
    chk(hresp, 32'h0, "response okay");
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task t_reset(input logic [3:0] fw);
    @(posedge hclk);
    hresetn <= 1'h0;
    fetch_wait <= fw;
    repeat (12) @(posedge hclk);
    #1;
    chk(condition_code_mask, 32'h0, "mask in reset");
    chk(vector_fetch_req, 32'h0, "fetch in reset");
    @(posedge hclk);
    hresetn <= 1'h1;
    repeat (2) @(posedge hclk);
    #1;
    chk(condition_code_mask, 32'h1, "mask first");
    chk(vector_fetch_req, 32'h0, "no fetch yet");
    @(posedge hclk);
    #1;
    chk(vector_fetch_req, 32'h1, "fetch");
    chk(vector_fetch_addr, 32'h0, "vector");
    for (i = 0; i < 30 && vector_fetch_req === 1'h1; i++) @(posedge hclk);
    chk(vector_fetch_req, 32'h0, "fetch end");
    rd(`OFS_RESET_STATE, 32'(RS_RUN), "running");
    rd(`OFS_PERIPH_FLAGS, 32'h0, "periph init");
    rd(`OFS_WAKE_FLAGS, 32'h0, "wake init");
    rd(`OFS_WAKE_EDGE, 32'h0, "edge init");
    $display("reset test done");
  endtask
  task t_periph;
    wr(`OFS_PERIPH_EN, 32'hff);
    wr(`OFS_CTRL, 32'h1);
    for (int k = 0; k < 6; k++) u_src.fire(k);
    rd(`OFS_PERIPH_FLAGS, 32'hcd, "all set");
    chk(periph_request, 32'hcd, "requests");
    wr(`OFS_PERIPH_FLAGS, 32'hff);
    rd(`OFS_PERIPH_FLAGS, 32'hcd, "one kept");
    wr(`OFS_PERIPH_FLAGS, 32'h4d);
    rd(`OFS_PERIPH_FLAGS, 32'h4d, "zero clears");
    wr(`OFS_PERIPH_EN, 32'h0);
    rd(`OFS_PERIPH_FLAGS, 32'h4d, "kept disabled");
    chk(periph_request, 32'h0, "no request");
    wr(`OFS_PERIPH_FLAGS, 32'h0);
    $display("peripheral test done");
  endtask
  task t_modes;
    wr(`OFS_CTRL, 32'h6);
    u_src.fire(0);
    u_src.fire(3);
    u_src.fire(5);
    rd(`OFS_PERIPH_FLAGS, 32'h0, "quiet 16");
    u_src.fire(4);
    u_src.fire(6);
    rd(`OFS_PERIPH_FLAGS, 32'h09, "16 bit");
    wr(`OFS_PERIPH_FLAGS, 32'h0);
    // Overflow lands in the data phase of the clearing write
    fork
      wr(`OFS_PERIPH_FLAGS, 32'h0);
      begin
        @(posedge hclk);
        u_src.fire(6);
      end
    join
    rd(`OFS_PERIPH_FLAGS, 32'h01, "set beats clear");
    wr(`OFS_PERIPH_FLAGS, 32'h0);
    $display("mode test done");
  endtask
  // Pins 3:0 rise and 7:4 fall, each against its own select
  task t_wake;
    wr(`OFS_WAKE_EDGE, 32'h0f);
    wr(`OFS_WAKE_CFG, 32'hff);
    rd(`OFS_WAKE_EDGE, 32'h0f, "edge rw");
    @(posedge hclk);
    wakeup_pin <= 8'h0f;
    repeat (6) @(posedge hclk);
    rd(`OFS_WAKE_FLAGS, 32'hff, "edges");
    chk(wakeup_request, 32'h1, "wake req");
    wr(`OFS_WAKE_FLAGS, 32'hff);
    rd(`OFS_WAKE_FLAGS, 32'hff, "one kept");
    wr(`OFS_WAKE_FLAGS, 32'h0);
    rd(`OFS_WAKE_FLAGS, 32'h0, "cleared");
    @(posedge hclk);
    wakeup_pin <= 8'hf0;
    repeat (6) @(posedge hclk);
    rd(`OFS_WAKE_FLAGS, 32'h0, "other edges");
    $display("wakeup test done");
  endtask
  task t_irq;
    // Earlier tests left both summary bits set
    wr(`OFS_EVT_STATUS, 32'h3);
    rd(`OFS_EVT_STATUS, 32'h0, "status cleared");
    wr(`OFS_CTRL, 32'h1);
    u_src.fire(0);
    wr(`OFS_EVT_MASK, 32'h0);
    rd(`OFS_EVT_STATUS, 32'h1, "status");
    chk(irq, 32'h0, "masked");
    wr(`OFS_EVT_MASK, 32'h3);
    rd(`OFS_EVT_MASK, 32'h3, "mask rw");
    chk(irq, 32'h1, "irq");
    wr(`OFS_PERIPH_FLAGS, 32'h0);
    wr(`OFS_EVT_STATUS, 32'h3);
    rd(`OFS_EVT_STATUS, 32'h0, "w1c");
    chk(irq, 32'h0, "irq low");
    wr(8'h3c, 32'hff);
    rd(8'h3c, 32'h0, "unmapped");
    $display("interrupt test done");
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    wakeup_pin = 8'hf0;
    fetch_wait = 4'h0;
    n_errors = 0;
    n_checks = 0;
    cycles = 0;
    t_reset(4'h0);
    t_periph;
    t_modes;
    t_wake;
    t_irq;
    u_src.fire(0);
    t_reset(4'h5);
    give_verdict;
  end
endmodule

// File: periph_source_model.sv
// Model of the event sources and of the CPU answering the reset vector fetch
`timescale 1ns/1ns
module periph_source_model (
  input wire logic hclk,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic [3:0] fetch_wait,
  output irq_flags_pkg::periph_events_t ev,
  output logic vector_done
);
  import irq_flags_pkg::*;
  // Idle compare bytes differ from the counts so that no match is seen
  localparam periph_events_t idle_ev = {1'h0, 1'h0, 8'h12, 8'h12, 8'hed, 8'hed, 1'h0, 1'h0};
  logic [3:0] wait_r;
  initial begin
    ev = idle_ev;
    vector_done = 1'h0;
    wait_r = 4'h0;
  end
  // Only a fetch from the reset vector is answered; a wrong address leaves the fetch pending and fails the fetch end check
  always @(posedge hclk) begin
    vector_done <= 1'h0;
    wait_r <= 4'h0;
    if (fetch_req === 1'h1 && fetch_addr === 16'h0000 && !vector_done) begin
      wait_r <= wait_r + 4'h1;
      if (wait_r >= fetch_wait) begin
        vector_done <= 1'h1;
      end
    end
  end
  // Each event lasts one cycle; the converter busy level falls when it ends
  task fire(input int k);
    @(posedge hclk);
    case (k)
      0: ev.sleep_direct <= 1'h1;
      1: ev.conv_end_busy_low <= 1'h1;
      // Single-byte matches move one count onto its compare so the other count byte stays unmatched
      2: ev.timer_count_high <= 8'hed;
      3: ev.timer_count_low <= 8'hed;
      4: begin
        ev.timer_compare_high <= 8'h12;
        ev.timer_compare_low <= 8'h12;
      end
      5: ev.event_count_lower_ovf <= 1'h1;
      default: ev.event_count_upper_ovf <= 1'h1;
    endcase
    @(posedge hclk);
    ev <= idle_ev;
    @(posedge hclk);
  endtask
endmodule

// File: reset_sequencer.sv
// Reset entry sequence: hold, set interrupt mask, fetch reset vector
`timescale 1ns/1ns
`include "irq_flags_defs.svh"
module reset_sequencer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic vector_done,
  output irq_flags_pkg::reset_ctl_t ctl,
  output irq_flags_pkg::reset_state_t state
);
  import irq_flags_pkg::*;
  reset_state_t state_r;
  reset_state_t state_nxt;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      RS_HALT: state_nxt = RS_MASK;
      RS_MASK: state_nxt = RS_FETCH;
      RS_FETCH: if (vector_done) state_nxt = RS_RUN;
      RS_RUN: state_nxt = RS_RUN;
    endcase
  end
  // Reset pin is the async reset; everything sits in halt while it is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) state_r <= RS_HALT;
    else state_r <= state_nxt;
  end
  assign state = state_r;
  assign ctl.mask_set = (state_r == RS_MASK);
  assign ctl.fetch_req = (state_r == RS_FETCH);
  assign ctl.fetch_addr = `RST_VECTOR_ADDR;
endmodule

// File: wake_edge_detect.sv
// Per-pin synchroniser and selectable edge detector for wakeup pins
`timescale 1ns/1ns
module wake_edge_detect (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] wakeup_pin,
  input wire logic [7:0] wakeup_edge_select,
  input wire logic [7:0] pin_is_wakeup,
  output logic [7:0] edge_seen
);
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] prev_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 8'hff;
      sync2_r <= 8'hff;
      prev_r <= 8'hff;
    end else begin
      sync1_r <= wakeup_pin;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      // Edge 0 selects falling, 1 selects rising
      assign edge_seen[i] = pin_is_wakeup[i] &&
        (wakeup_edge_select[i] ? (sync2_r[i] && !prev_r[i]) : (!sync2_r[i] && prev_r[i]));
    end
  endgenerate
endmodule
